// >>> fp_coprocessor_instr_decode_tb.sv
`timescale 1ns/100ps
module fp_coprocessor_instr_decode_tb
  import fpd_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, illegal_ff, pow2_ff, accept_ff;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, d;
  logic [2:0] md, rg, fm;
  logic bad;
  int n_errors = 0;
  int n_compared = 0;

  fpd_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  fpd_decoder uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .illegal_ff(illegal_ff), .pow2_ff(pow2_ff), .accept_ff(accept_ff));

  // ****************************************
  // clock, watchdog
  // ****************************************
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // whole run is well under a thousand cycles; five thousand means a hang
  initial
  begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    $display("watchdog expired");
    print_verdict();
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    host.bus_xfer(1'b0, addr, 32'h0000_0000, r);
    check(r & mask, exp);
  endtask : rd_chk

  // decode one instruction; status bits {ea_bad,same,rm,pow2,accept,illegal}
  task automatic decode(input logic [15:0] op, input logic [15:0] cmd, input logic [5:0] st,
                        input logic [5:0] mask);
    host.issue_instr(op, cmd);
    check({29'h0, illegal_ff, accept_ff, pow2_ff}, {29'h0, st[0], st[1], st[2]});
    rd_chk(FPD_ADDR_STATUS, {26'h0, mask}, {26'h0, st & mask});
  endtask : decode

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, unmapped place, response code
    rd_chk(FPD_ADDR_CTRL, 32'h0000_0007, 32'h0000_0001);
    rd_chk(FPD_ADDR_STATUS, 32'h0000_003f, 32'h0000_0000);
    host.bus_xfer(1'b1, 8'h14, 32'h0000_0005, d);
    rd_chk(8'h14, 32'hffff_ffff, 32'h0000_0000);
    rd_chk(FPD_ADDR_CTRL, 32'h0000_0007, 32'h0000_0001);
    check({31'h0, hresp}, 32'h0000_0000);
    check({31'h0, hreadyout}, 32'h0000_0001);
    $display("test registers done");
    // every type code, power-of-two extension only meaningful for general type
    for (int t = 0; t < 8; t++)
    begin
      decode({4'hf, 3'd1, t[2:0], 6'h00}, 16'h0011, {3'b000, t == 0, t < 6, t >= 6}, 6'h07);
      rd_chk(FPD_ADDR_DECODE, 32'h0000_0007, {29'h0, t[2:0]});
    end
    $display("test type codes done");
    // wrong line code, then id selection
    decode({4'he, 3'd1, 3'd0, 6'h00}, 16'h0011, 6'h00, 6'h07);
    host.bus_xfer(1'b1, FPD_ADDR_CTRL, 32'h0000_0002, d);
    decode({4'hf, 3'd1, 3'd0, 6'h00}, 16'h0011, 6'h00, 6'h07);
    decode({4'hf, 3'd2, 3'd0, 6'h00}, 16'h0011, 6'h06, 6'h07);
    host.bus_xfer(1'b1, FPD_ADDR_CTRL, 32'h0000_0001, d);
    $display("test line code and id done");
    // register mode with a nonzero unused field, same source and destination
    decode({4'hf, 3'd1, 3'd0, 6'h3f}, {3'b000, 3'd3, 3'd3, FPD_EXT_POW2}, 6'h16, 6'h1f);
    decode({4'hf, 3'd1, 3'd0, 6'h00}, {3'b000, 3'd2, 3'd5, FPD_EXT_POW2}, 6'h06, 6'h1f);
    rd_chk(FPD_ADDR_DECODE, 32'h0000_007f, 32'h0000_0010);
    $display("test register mode done");
    // memory source: data-register direct per format, every mode, every special code
    for (int i = 0; i < 21; i++)
    begin
      md = (i < 7) ? 3'd0 : (i < 13) ? 3'(i - 6) : 3'd7;
      rg = (i < 13) ? 3'd3 : 3'(i - 13);
      fm = (i < 7) ? 3'(i) : FPD_FMT_EXT;
      bad = (md == 3'd1) || (md == 3'd0 && (fm == 3'd2 || fm == 3'd3 || fm == 3'd5)) || (md == 3'd7 && rg > 3'd4);
      decode({4'hf, 3'd1, 3'd0, md, rg}, {3'b010, fm, 3'd1, 7'h22}, {bad, 2'b01, 1'b0, !bad, bad}, 6'h2f);
      if (i == 17)
        rd_chk(FPD_ADDR_DECODE, 32'h0000_007f, 32'h0000_0040);
    end
    decode({4'hf, 3'd1, 3'd0, FPD_M_IND, 3'd3}, {3'b010, 3'd7, 3'd1, 7'h22}, 6'h29, 6'h2f);
    $display("test memory source done");
    print_verdict();
  end
endmodule : fp_coprocessor_instr_decode_tb

// >>> fpd_decoder.sv
`timescale 1ns/100ps
module fpd_decoder
  import fpd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic illegal_ff,
  output logic pow2_ff,
  output logic accept_ff
);
  // ****************************************
  // bus slave
  // ****************************************
  // bus capture state and decoded result registers
  logic wr_pend_ff, nxt_wr_pend;
  logic rd_pend_ff, nxt_rd_pend;
  logic [7:0] addr_ff, nxt_addr;
  logic [15:0] op_ff, nxt_op;
  logic [15:0] cmd_ff, nxt_cmd;
  logic [2:0] id_ff, nxt_id;
  logic [31:0] rdata_ff, nxt_rdata;
  logic go_ff, nxt_go;
  logic ill_ff, nxt_ill;
  logic p2_ff, nxt_p2;
  logic acc_ff, nxt_acc;
  logic [3:0] words_ff, nxt_words;
  logic [2:0] class_ff, nxt_class;
  logic ea_bad_ff, nxt_ea_bad;
  logic same_ff, nxt_same;
  logic rm_ff, nxt_rm;
  // combinational fields of the stored words
  logic is_cop, id_hit, type_res, rm, ea_used, ea_ok, same, ea_zero;
  logic [2:0] itype, spec, dst, ea_mode, ea_reg;
  logic [3:0] ext_words, len;
  logic is_pow2;
  // address phase capture; single-wait-free slave, data phase one cycle
  always_comb
  begin
    nxt_wr_pend = 1'b0;
    nxt_rd_pend = 1'b0;
    nxt_addr = addr_ff;
    if (hsel && hready && htrans[1])
    begin
      nxt_wr_pend = hwrite;
      nxt_rd_pend = !hwrite;
      nxt_addr = haddr;
    end
  end
  // ****************************************
  // field extraction
  // ****************************************
  // operation word fields first, then command word fields
  assign is_cop = op_ff[15:12] == FPD_LINE_CODE;
  assign id_hit = op_ff[11:9] == id_ff;
  assign itype = op_ff[8:6];
  assign type_res = itype[2] && itype[1];
  assign ea_mode = op_ff[5:3];
  assign ea_reg = op_ff[2:0];
  assign rm = cmd_ff[14];
  assign spec = cmd_ff[12:10];
  assign dst = cmd_ff[9:7];
  assign same = !rm && (spec == dst);
  assign ea_zero = op_ff[5:0] == 6'h00;
  // register source ignores the ea field entirely, zero or not
  assign ea_used = rm && (itype == FPD_T_GEN);
  assign is_pow2 = (itype == FPD_T_GEN) && !cmd_ff[15] && !cmd_ff[13]
                   && cmd_ff[6:0] == FPD_EXT_POW2;
  // legality of the external source, data-direct only for narrow formats
  always_comb
  begin
    ea_ok = 1'b1;
    case (ea_mode)
      FPD_M_DREG: ea_ok = spec == FPD_FMT_LONG || spec == FPD_FMT_SINGLE
                          || spec == FPD_FMT_WORD || spec == FPD_FMT_BYTE;
      FPD_M_AREG: ea_ok = 1'b0;
      FPD_M_SPEC: ea_ok = ea_reg <= FPD_R_IMM;
      default: ea_ok = 1'b1;
    endcase
    if (spec == 3'h7)
    begin
      ea_ok = 1'b0;
    end
  end
  // extension words the host must supply after the command word
  always_comb
  begin
    ext_words = 4'h0;
    case (itype)
      FPD_T_GEN:
      begin
        if (rm)
        begin
          case (ea_mode)
            FPD_M_DISP: ext_words = 4'h1;
            FPD_M_IDX: ext_words = 4'h1;
            FPD_M_SPEC:
            begin
              case (ea_reg)
                FPD_R_ABSW: ext_words = 4'h1;
                FPD_R_ABSL: ext_words = 4'h2;
                FPD_R_PCD: ext_words = 4'h1;
                FPD_R_PCX: ext_words = 4'h1;
                FPD_R_IMM:
                begin
                  case (spec)
                    FPD_FMT_EXT: ext_words = 4'h6;
                    FPD_FMT_PACKED: ext_words = 4'h6;
                    FPD_FMT_DOUBLE: ext_words = 4'h4;
                    FPD_FMT_LONG: ext_words = 4'h2;
                    FPD_FMT_SINGLE: ext_words = 4'h2;
                    default: ext_words = 4'h1;
                  endcase
                end
                default: ext_words = 4'h0;
              endcase
            end
            default: ext_words = 4'h0;
          endcase
        end
      end
      FPD_T_BRS: ext_words = 4'h0;
      FPD_T_BRL: ext_words = 4'h1;
      default: ext_words = 4'h0;
    endcase
  end
  // two leading words plus whatever the address mode or the long branch type needs
  assign len = 4'h2 + ext_words;
  // ****************************************
  // decode and register update
  // ****************************************
  // register writes; decode runs the cycle after the command word lands
  always_comb
  begin
    nxt_op = op_ff;
    nxt_cmd = cmd_ff;
    nxt_id = id_ff;
    nxt_go = 1'b0;
    if (wr_pend_ff)
    begin
      case (addr_ff)
        FPD_ADDR_OPWORD: nxt_op = hwdata[15:0];
        FPD_ADDR_CMDWORD:
        begin
          nxt_cmd = hwdata[15:0];
          nxt_go = 1'b1;
        end
        FPD_ADDR_CTRL: nxt_id = hwdata[2:0];
        default: nxt_id = id_ff;
      endcase
    end
    nxt_ill = ill_ff;
    nxt_p2 = p2_ff;
    nxt_acc = acc_ff;
    nxt_words = words_ff;
    nxt_class = class_ff;
    nxt_ea_bad = ea_bad_ff;
    nxt_same = same_ff;
    nxt_rm = rm_ff;
    if (go_ff && is_cop && id_hit)
    begin
      nxt_ill = type_res || (ea_used && !ea_ok);
      nxt_acc = !nxt_ill;
      nxt_p2 = is_pow2 && !nxt_ill;
      nxt_words = len;
      nxt_class = itype;
      nxt_ea_bad = ea_used && !ea_ok;
      nxt_same = same && (itype == FPD_T_GEN);
      nxt_rm = rm;
    end
    else if (go_ff)
    begin
      nxt_ill = 1'b0;
      nxt_acc = 1'b0;
      nxt_p2 = 1'b0;
    end
    nxt_rdata = 32'h0000_0000;
    if (rd_pend_ff || (hsel && hready && htrans[1] && !hwrite))
    begin
      case (rd_pend_ff ? addr_ff : haddr)
        FPD_ADDR_OPWORD: nxt_rdata = {16'h0000, op_ff};
        FPD_ADDR_CMDWORD: nxt_rdata = {16'h0000, cmd_ff};
        FPD_ADDR_STATUS: nxt_rdata = {26'h000_0000, ea_bad_ff, same_ff, rm_ff, p2_ff, acc_ff, ill_ff};
        FPD_ADDR_DECODE: nxt_rdata = {25'h000_0000, words_ff, class_ff};
        FPD_ADDR_CTRL: nxt_rdata = {29'h0000_0000, id_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end
  // every register updates on every edge; reset loads constants only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      op_ff <= 16'h0000;
      cmd_ff <= 16'h0000;
      id_ff <= FPD_ID_RESET;
      rdata_ff <= 32'h0000_0000;
      go_ff <= 1'b0;
      ill_ff <= 1'b0;
      p2_ff <= 1'b0;
      acc_ff <= 1'b0;
      words_ff <= 4'h0;
      class_ff <= 3'h0;
      ea_bad_ff <= 1'b0;
      same_ff <= 1'b0;
      rm_ff <= 1'b0;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      addr_ff <= nxt_addr;
      op_ff <= nxt_op;
      cmd_ff <= nxt_cmd;
      id_ff <= nxt_id;
      rdata_ff <= nxt_rdata;
      go_ff <= nxt_go;
      ill_ff <= nxt_ill;
      p2_ff <= nxt_p2;
      acc_ff <= nxt_acc;
      words_ff <= nxt_words;
      class_ff <= nxt_class;
      ea_bad_ff <= nxt_ea_bad;
      same_ff <= nxt_same;
      rm_ff <= nxt_rm;
    end
  end
  // read data registered at the address phase, so it stands in the data phase
  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign illegal_ff = ill_ff;
  assign pow2_ff = p2_ff;
  assign accept_ff = acc_ff;
  // ****************************************
  // checks
  // ****************************************
  // reserved types must be refused, never accepted
  a_reserved_type: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && type_res |=> ill_ff && !acc_ff) else $error("reserved type not refused");
  a_pow2_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && is_pow2 && !type_res && !(ea_used && !ea_ok) |=> p2_ff) else $error("pow2 missed");
  // the predicate word of other types never names an operation
  a_cond_no_pow2: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && itype != FPD_T_GEN |=> !p2_ff) else $error("pow2 on non general type");
  // a nonzero field that nobody reads must not stop the instruction
  a_ea_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && !rm && itype == FPD_T_GEN && !ea_zero |=> acc_ff) else $error("unused ea refused");
  // external source legality per mode and format
  a_areg_direct: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && ea_used && ea_mode == FPD_M_AREG |=> ill_ff) else $error("address direct taken");
  a_dreg_fmt: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && ea_used && ea_mode == FPD_M_DREG && spec == FPD_FMT_DOUBLE |=> ill_ff)
    else $error("data direct double taken");
  a_dreg_narrow: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && ea_used && ea_mode == FPD_M_DREG && spec == FPD_FMT_BYTE |=> acc_ff)
    else $error("data direct byte refused");
  a_abs_long: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && ea_used && ea_mode == FPD_M_SPEC && ea_reg == FPD_R_ABSL && spec != 3'h7
    |=> acc_ff) else $error("absolute long refused");
  a_special_code: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && ea_used && ea_mode == FPD_M_SPEC && ea_reg > FPD_R_IMM |=> ill_ff)
    else $error("undefined special code taken");
  // an eighth code in the format field has no meaning
  a_spec_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && ea_used && spec == 3'h7 |=> ill_ff && !acc_ff) else $error("reserved format taken");
  // length is bounded by the longest immediate operand
  a_len_range: assert property (@(posedge hclk) disable iff (!hresetn)
    acc_ff |-> words_ff >= 4'h2 && words_ff <= 4'h8) else $error("length out of range");
  a_imm_long: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && ea_used && ea_mode == FPD_M_SPEC && ea_reg == FPD_R_IMM
    && (spec == FPD_FMT_EXT || spec == FPD_FMT_PACKED) |=> words_ff == 4'h8)
    else $error("long immediate length wrong");
  // words meant for another unit leave no trace in the flags
  a_foreign_id: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && !(is_cop && id_hit) |=> !acc_ff && !ill_ff) else $error("foreign word decoded");
  // decoded fields are kept for software to read back
  a_same_reg: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit && itype == FPD_T_GEN && same |=> same_ff && !rm_ff) else $error("same reg lost");
  a_class_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit |=> class_ff == $past(itype)) else $error("class wrong");
  a_rm_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    go_ff && is_cop && id_hit |=> rm_ff == $past(rm)) else $error("source select lost");
  // ****************************************
  // scenario coverage
  // ****************************************
  c_pow2: cover property (@(posedge hclk) disable iff (!hresetn) p2_ff);
  c_illegal: cover property (@(posedge hclk) disable iff (!hresetn) ill_ff);
  c_long_imm: cover property (@(posedge hclk) disable iff (!hresetn) acc_ff && words_ff == 4'h8);
  c_same_reg: cover property (@(posedge hclk) disable iff (!hresetn) same_ff && acc_ff);
  c_foreign: cover property (@(posedge hclk) disable iff (!hresetn) go_ff && !(is_cop && id_hit));
endmodule : fpd_decoder

// >>> fpd_host_model.sv
`timescale 1ns/100ps
// host side: an ahb-lite master that hands over instruction words
module fpd_host_model
  import fpd_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // one single word transfer; caller enters just after a rising edge
  task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wdata : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rdata = hrdata;
    // a released data bus must not keep its last value
    hwdata <= ~hwdata;
  endtask : bus_xfer

  // operation word first, then the word that triggers the decode
  task automatic issue_instr(input logic [15:0] op, input logic [15:0] cmd);
    logic [31:0] dummy;
    bus_xfer(1'b1, FPD_ADDR_OPWORD, {16'h0000, op}, dummy);
    bus_xfer(1'b1, FPD_ADDR_CMDWORD, {16'h0000, cmd}, dummy);
    repeat (3) @(posedge hclk);
  endtask : issue_instr
endmodule : fpd_host_model

// >>> fpd_pkg.sv
package fpd_pkg;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] FPD_ADDR_OPWORD = 8'h00;
  localparam logic [7:0] FPD_ADDR_CMDWORD = 8'h04;
  localparam logic [7:0] FPD_ADDR_STATUS = 8'h08;
  localparam logic [7:0] FPD_ADDR_DECODE = 8'h0c;
  localparam logic [7:0] FPD_ADDR_CTRL = 8'h10;
  localparam logic [3:0] FPD_LINE_CODE = 4'hf;
  localparam logic [2:0] FPD_ID_RESET = 3'h1;
  localparam logic [6:0] FPD_EXT_POW2 = 7'h11;
  localparam logic [2:0] FPD_T_GEN = 3'h0;
  localparam logic [2:0] FPD_T_COND = 3'h1;
  localparam logic [2:0] FPD_T_BRS = 3'h2;
  localparam logic [2:0] FPD_T_BRL = 3'h3;
  localparam logic [2:0] FPD_T_SAVE = 3'h4;
  localparam logic [2:0] FPD_T_REST = 3'h5;
  localparam logic [2:0] FPD_FMT_LONG = 3'h0;
  localparam logic [2:0] FPD_FMT_SINGLE = 3'h1;
  localparam logic [2:0] FPD_FMT_EXT = 3'h2;
  localparam logic [2:0] FPD_FMT_PACKED = 3'h3;
  localparam logic [2:0] FPD_FMT_WORD = 3'h4;
  localparam logic [2:0] FPD_FMT_DOUBLE = 3'h5;
  localparam logic [2:0] FPD_FMT_BYTE = 3'h6;
  localparam logic [2:0] FPD_M_DREG = 3'h0;
  localparam logic [2:0] FPD_M_AREG = 3'h1;
  localparam logic [2:0] FPD_M_IND = 3'h2;
  localparam logic [2:0] FPD_M_DISP = 3'h5;
  localparam logic [2:0] FPD_M_IDX = 3'h6;
  localparam logic [2:0] FPD_M_SPEC = 3'h7;
  localparam logic [2:0] FPD_R_ABSW = 3'h0;
  localparam logic [2:0] FPD_R_ABSL = 3'h1;
  localparam logic [2:0] FPD_R_PCD = 3'h2;
  localparam logic [2:0] FPD_R_PCX = 3'h3;
  localparam logic [2:0] FPD_R_IMM = 3'h4;
  typedef enum logic [1:0] {FPD_IDLE, FPD_DATA} fpd_bus_type;
endpackage : fpd_pkg
